// [pmc_pkg.sv]
// pmc_pkg: constants shared by the peripheral mode configuration loader
// assumes: byte-wide loading, least significant bit serialized first
package pmc_pkg;

  // mode select pin patterns, highest pin first
  localparam logic [2:0] PMC_MODE_SYNC = 3'h3;
  localparam logic [2:0] PMC_MODE_ASYNC = 3'h5;

  // byte and serializer layout
  localparam int PMC_BYTE_W = 8;
  localparam logic [3:0] PMC_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] PMC_ASYNC_STALL_LEFT = 4'h2;
  localparam logic [3:0] PMC_LAST_BIT_LEFT = 4'h1;

  // synchronous mode capture pacing, in rising link edges
  localparam logic [2:0] PMC_BYTE_PERIOD_LAST = 3'h7;

  // status byte: ready bit on top, all others forced high
  localparam int PMC_STATUS_READY_BIT = 7;
  localparam logic [6:0] PMC_STATUS_FILL = 7'h7F;

  // system clock rate
  localparam int PMC_CLK_SYS_MHZ = 40;

endpackage

// [pmc_ser_if.sv]
// pmc_ser_if: link between the loader control and its serializer
// assumes: all signals live in the link clock domain
`timescale 1ns/1ps
interface pmc_ser_if;
  import pmc_pkg::*;

  logic load_valid;
  logic [PMC_BYTE_W-1:0] load_byte;
  logic stall_en;
  logic hold_full;
  logic bit_data;
  logic bit_valid;
  logic chain_bit;

  modport ctrl (
    output load_valid,
    output load_byte,
    output stall_en,
    input hold_full,
    input bit_data,
    input bit_valid,
    input chain_bit
  );

  modport ser (
    input load_valid,
    input load_byte,
    input stall_en,
    output hold_full,
    output bit_data,
    output bit_valid,
    output chain_bit
  );
endinterface

// [pmc_serializer.sv]
// pmc_serializer: holding buffer plus shift register, bit 0 first
// assumes: link clock and its synchronous reset; loads only when needed
`timescale 1ns/1ps
module pmc_serializer
  import pmc_pkg::*;
(
  // link clock and reset
  input wire logic link_clk,
  input wire logic link_reset,
  // control side
  pmc_ser_if.ser sif
);

  typedef struct packed {
    logic [PMC_BYTE_W-1:0] hold;
    logic hold_full;
    logic [PMC_BYTE_W-1:0] sh;
    logic [3:0] left;
    logic bit_data;
    logic bit_valid;
    logic parked;
  } pmc_ser_s;

  pmc_ser_s st_r;
  pmc_ser_s st_nxt;
  logic chain_r;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.bit_valid = 1'b0;
    // buffer moves on when register is empty or on its last bit
    if (st_r.hold_full && st_r.left <= PMC_LAST_BIT_LEFT) begin // [R10]
      if (st_r.left == PMC_LAST_BIT_LEFT) begin
        st_nxt.bit_data = st_r.sh[0];
        st_nxt.bit_valid = 1'b1;
      end
      st_nxt.sh = st_r.hold;
      st_nxt.left = PMC_BITS_PER_BYTE;
      st_nxt.hold_full = 1'b0;
    end else if (st_r.left != 4'h0) begin
      // async: last byte parks with bit 6 shown, bit 6 handed over once
      if (sif.stall_en && !st_r.hold_full &&
          st_r.left == PMC_ASYNC_STALL_LEFT) begin // [R14]
        st_nxt.bit_data = st_r.sh[0];
        st_nxt.bit_valid = !st_r.parked;
        st_nxt.parked = 1'b1;
      end else begin
        st_nxt.bit_data = st_r.sh[0];
        st_nxt.bit_valid = !st_r.parked;
        st_nxt.parked = 1'b0;
        st_nxt.sh = st_r.sh >> 1;
        st_nxt.left = st_r.left - 4'h1;
      end
    end
    if (sif.load_valid) begin // [R10]
      st_nxt.hold = sif.load_byte;
      st_nxt.hold_full = 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // chain output follows the shown bit on the falling edge
  always_ff @(negedge link_clk) begin
    if (link_reset) begin
      chain_r <= 1'b1;
    end else if (st_r.left != 4'h0) begin
      chain_r <= st_r.sh[0]; // [R5]
    end
  end

  assign sif.hold_full = st_r.hold_full;
  assign sif.bit_data = st_r.bit_data;
  assign sif.bit_valid = st_r.bit_valid;
  assign sif.chain_bit = chain_r;

endmodule

// [pmc_config_loader.sv]
// pmc_config_loader: byte-wide peripheral mode configuration loading
// assumes: config_clock is the link clock, synchronous mode data
// meets setup to it; status reads run on clk_sys
//
// Function
// R1: mode pins 011 select synchronous loading
// R2: first byte on second edge after init
// R3: later bytes every eighth rising edge
// R4: capture edge gives one-period ready pulse
// R5: chain output changes on falling edges
// R6: source adds ten edges plus chain edges
// R7: ready released, not driven, before init
// R8: mode pins 101 select asynchronous loading
// R9: accept byte at write condition end
// R10: holding buffer feeds separate shift register
// R11: busy from receipt until buffer moves on
// R12: host ends write after ready period
// R13: busy two periods, up to nine
// R14: last async byte stops after seven bits
// R15: host skips handshake only if slow
// R16: status drives bus during read condition
// R17: status bit 7 ready, others high
// R18: host finishes start-up with one write
// R19: bus released outside status reads
`timescale 1ns/1ps
module pmc_config_loader
  import pmc_pkg::*;
#(
  parameter int DATA_W = PMC_BYTE_W
)
(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // link clock
  input wire logic config_clock,
  // mode and start
  input wire logic [2:0] mode_select_pins,
  input wire logic init_pin,
  // host strobes
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic chip_select_lo_n,
  input wire logic chip_select_hi,
  // byte bus, two-way
  input wire logic [DATA_W-1:0] config_byte_bus_i,
  output logic [DATA_W-1:0] config_byte_bus_o,
  output logic [DATA_W-1:0] config_byte_bus_oe,
  // ready or busy pin
  output logic rdy_busy_o,
  output logic rdy_busy_oe,
  // serial chain and internal stream
  output logic serial_chain_out,
  output logic cfg_bit,
  output logic cfg_bit_valid,
  // system side status
  output logic status_ready,
  output logic sync_mode_active,
  output logic async_mode_active
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (DATA_W != PMC_BYTE_W) begin : g_width_check
    $error("pmc_config_loader: DATA_W must equal the byte width");
  end

  if (PMC_BITS_PER_BYTE != 4'(PMC_BYTE_W)) begin : g_bits_check
    $error("pmc_config_loader: bit count must match the byte width");
  end

  if (PMC_BYTE_PERIOD_LAST != 3'(PMC_BYTE_W - 1)) begin : g_period_check
    $error("pmc_config_loader: capture period must span one byte");
  end

  if (PMC_STATUS_READY_BIT != PMC_BYTE_W - 1) begin : g_ready_bit_check
    $error("pmc_config_loader: ready bit must be the top status bit");
  end

  if (PMC_STATUS_FILL != '1) begin : g_fill_check
    $error("pmc_config_loader: status fill bits must all be high");
  end

  if (PMC_LAST_BIT_LEFT == 4'h0) begin : g_last_check
    $error("pmc_config_loader: last bit count must not be zero");
  end

  if (PMC_ASYNC_STALL_LEFT <= PMC_LAST_BIT_LEFT) begin : g_stall_order_check
    $error("pmc_config_loader: stall point must precede the last bit");
  end

  if (PMC_ASYNC_STALL_LEFT >= PMC_BITS_PER_BYTE) begin : g_stall_range_check
    $error("pmc_config_loader: stall point must lie inside the byte");
  end

  if (PMC_MODE_SYNC == PMC_MODE_ASYNC) begin : g_mode_check
    $error("pmc_config_loader: mode patterns must differ");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic write_cond(input logic ws_n, input logic rs_n,
                                      input logic cs_lo_n, input logic cs_hi);
    write_cond = !ws_n && !cs_lo_n && rs_n && cs_hi;
  endfunction

  function automatic logic read_cond(input logic ws_n, input logic rs_n,
                                     input logic cs_lo_n, input logic cs_hi);
    read_cond = ws_n && !rs_n && !cs_lo_n && cs_hi;
  endfunction

  function automatic logic mode_is(input logic [2:0] pins, input logic [2:0] code);
    mode_is = (pins == code);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link domain reset

  logic link_rst_m_r;
  logic link_rst_r;

  always_ff @(posedge config_clock) begin
    link_rst_m_r <= reset;
    link_rst_r <= link_rst_m_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain state

  typedef struct packed {
    logic [2:0] mode_m;
    logic [2:0] mode_s;
    logic init_m;
    logic init_s;
    logic ws_m;
    logic ws_s;
    logic rs_m;
    logic rs_s;
    logic cslo_m;
    logic cslo_s;
    logic cshi_m;
    logic cshi_s;
    logic [PMC_BYTE_W-1:0] bus_m;
    logic [PMC_BYTE_W-1:0] bus_s;
    logic wr_prev;
    logic [PMC_BYTE_W-1:0] wr_data;
    logic sync_run;
    logic [2:0] sync_cnt;
    logic rdy;
    logic rdy_oe;
    logic bit_data;
    logic bit_valid;
  } pmc_link_s;

  pmc_link_s lk_r;
  pmc_link_s lk_nxt;

  pmc_ser_if sif ();

  logic is_sync;
  logic is_async;
  logic wr_now;
  logic wr_trail;
  logic sync_capture;

  always_comb begin
    is_sync = mode_is(lk_r.mode_s, PMC_MODE_SYNC); // [R1]
    is_async = mode_is(lk_r.mode_s, PMC_MODE_ASYNC); // [R8]
    wr_now = write_cond(lk_r.ws_s, lk_r.rs_s, lk_r.cslo_s, lk_r.cshi_s);
    // byte taken when the write condition ends
    wr_trail = is_async && lk_r.init_s && lk_r.wr_prev && !wr_now; // [R9]
    sync_capture = is_sync && lk_r.init_s && lk_r.sync_run &&
                   (lk_r.sync_cnt == 3'h0); // [R2] [R3]
  end

  always_comb begin
    lk_nxt = lk_r;
    // pin synchronisers
    lk_nxt.mode_m = mode_select_pins;
    lk_nxt.mode_s = lk_r.mode_m;
    lk_nxt.init_m = init_pin;
    lk_nxt.init_s = lk_r.init_m;
    lk_nxt.ws_m = write_strobe_n;
    lk_nxt.ws_s = lk_r.ws_m;
    lk_nxt.rs_m = read_strobe_n;
    lk_nxt.rs_s = lk_r.rs_m;
    lk_nxt.cslo_m = chip_select_lo_n;
    lk_nxt.cslo_s = lk_r.cslo_m;
    lk_nxt.cshi_m = chip_select_hi;
    lk_nxt.cshi_s = lk_r.cshi_m;
    lk_nxt.bus_m = config_byte_bus_i;
    lk_nxt.bus_s = lk_r.bus_m;
    // async: hold the last byte seen while writing
    lk_nxt.wr_prev = wr_now;
    // data taken once the condition stood an edge, bus bits settled
    if (wr_now && lk_r.wr_prev) begin
      lk_nxt.wr_data = lk_r.bus_s;
    end
    // sync: first edge arms, next captures, then every eighth
    if (!lk_r.init_s || !is_sync) begin
      lk_nxt.sync_run = 1'b0;
      lk_nxt.sync_cnt = 3'h0;
    end else if (!lk_r.sync_run) begin
      lk_nxt.sync_run = 1'b1; // [R2]
      lk_nxt.sync_cnt = 3'h0;
    end else if (lk_r.sync_cnt == 3'h0) begin
      lk_nxt.sync_cnt = PMC_BYTE_PERIOD_LAST; // [R3]
    end else begin
      lk_nxt.sync_cnt = lk_r.sync_cnt - 3'h1;
    end
    // ready pin: only driven once init is seen high
    lk_nxt.rdy_oe = lk_r.init_s && (is_sync || is_async); // [R7]
    if (is_sync) begin
      lk_nxt.rdy = sync_capture; // [R4]
    end else if (is_async) begin
      // low on receipt, high after buffer empties
      lk_nxt.rdy = !(wr_trail || sif.hold_full); // [R11] [R13]
    end else begin
      lk_nxt.rdy = 1'b1;
    end
    // internal bit stream
    lk_nxt.bit_data = sif.bit_data;
    lk_nxt.bit_valid = sif.bit_valid;
  end

  always_ff @(posedge config_clock) begin
    if (link_rst_r) begin
      lk_r <= '0;
      lk_r.ws_m <= 1'b1;
      lk_r.ws_s <= 1'b1;
      lk_r.rs_m <= 1'b1;
      lk_r.rs_s <= 1'b1;
      lk_r.cslo_m <= 1'b1;
      lk_r.cslo_s <= 1'b1;
      lk_r.rdy <= 1'b1;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serializer

  always_comb begin
    sif.load_valid = sync_capture || wr_trail; // [R10]
    // sync: bus is synchronous to the link clock, taken direct
    sif.load_byte = sync_capture ? config_byte_bus_i : lk_r.wr_data;
    sif.stall_en = is_async; // [R14]
  end

  pmc_serializer u_ser (
    .link_clk(config_clock),
    .link_reset(link_rst_r),
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////////////
  // link domain outputs

  assign serial_chain_out = sif.chain_bit; // [R5]
  assign cfg_bit = lk_r.bit_data;
  assign cfg_bit_valid = lk_r.bit_valid;
  assign rdy_busy_o = lk_r.rdy;
  assign rdy_busy_oe = lk_r.rdy_oe; // [R7]

  ////////////////////////////////////////////////////////////////////////
  // system domain: status read

  typedef struct packed {
    logic ws_m;
    logic ws_s;
    logic rs_m;
    logic rs_s;
    logic cslo_m;
    logic cslo_s;
    logic cshi_m;
    logic cshi_s;
    logic rdy_m;
    logic rdy_s;
    logic [2:0] mode_m;
    logic [2:0] mode_s;
    logic sync_on;
    logic async_on;
    logic [PMC_BYTE_W-1:0] bus_o;
    logic bus_oe;
  } pmc_sys_s;

  pmc_sys_s sy_r;
  pmc_sys_s sy_nxt;
  logic rd_now;

  always_comb begin
    sy_nxt = sy_r;
    sy_nxt.ws_m = write_strobe_n;
    sy_nxt.ws_s = sy_r.ws_m;
    sy_nxt.rs_m = read_strobe_n;
    sy_nxt.rs_s = sy_r.rs_m;
    sy_nxt.cslo_m = chip_select_lo_n;
    sy_nxt.cslo_s = sy_r.cslo_m;
    sy_nxt.cshi_m = chip_select_hi;
    sy_nxt.cshi_s = sy_r.cshi_m;
    sy_nxt.rdy_m = lk_r.rdy;
    sy_nxt.rdy_s = sy_r.rdy_m;
    sy_nxt.mode_m = mode_select_pins;
    sy_nxt.mode_s = sy_r.mode_m;
    sy_nxt.sync_on = mode_is(sy_r.mode_s, PMC_MODE_SYNC); // [R1]
    sy_nxt.async_on = mode_is(sy_r.mode_s, PMC_MODE_ASYNC); // [R8]
    // status reads only exist in async mode
    rd_now = read_cond(sy_r.ws_s, sy_r.rs_s, sy_r.cslo_s, sy_r.cshi_s) &&
             mode_is(sy_r.mode_s, PMC_MODE_ASYNC);
    // released whenever no status read is under way
    sy_nxt.bus_oe = rd_now; // [R16] [R19]
    sy_nxt.bus_o[PMC_STATUS_READY_BIT-1:0] = PMC_STATUS_FILL; // [R17]
    sy_nxt.bus_o[PMC_STATUS_READY_BIT] = sy_r.rdy_s; // [R17]
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sy_r <= '0;
      sy_r.ws_m <= 1'b1;
      sy_r.ws_s <= 1'b1;
      sy_r.rs_m <= 1'b1;
      sy_r.rs_s <= 1'b1;
      sy_r.cslo_m <= 1'b1;
      sy_r.cslo_s <= 1'b1;
      sy_r.rdy_m <= 1'b1;
      sy_r.rdy_s <= 1'b1;
      sy_r.bus_o <= {1'b1, PMC_STATUS_FILL};
    end else begin
      sy_r <= sy_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system domain outputs

  assign config_byte_bus_o = sy_r.bus_o;
  assign config_byte_bus_oe = {DATA_W{sy_r.bus_oe}}; // [R19]
  assign status_ready = sy_r.rdy_s;
  assign sync_mode_active = sy_r.sync_on;
  assign async_mode_active = sy_r.async_on;

endmodule

// [pmc_config_monitor.sv]
// pmc_config_monitor: port checks for the configuration loader
// assumes: bound to pmc_config_loader, mode pins steady within a test
`timescale 1ns/1ps
module pmc_config_monitor
  import pmc_pkg::*;
#(
  parameter int DATA_W = PMC_BYTE_W
)
(
  // clocks and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic config_clock,
  // pins
  input wire logic [2:0] mode_select_pins,
  input wire logic init_pin,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic chip_select_lo_n,
  input wire logic chip_select_hi,
  // outputs watched
  input wire logic [DATA_W-1:0] config_byte_bus_o,
  input wire logic [DATA_W-1:0] config_byte_bus_oe,
  input wire logic rdy_busy_o,
  input wire logic rdy_busy_oe,
  input wire logic sync_mode_active,
  input wire logic async_mode_active
);
  logic rd_c;
  assign rd_c = !read_strobe_n && write_strobe_n && !chip_select_lo_n && chip_select_hi;
  ////////////////////////////////////////
  sequence rd_hold_s;
    (rd_c && mode_select_pins == PMC_MODE_ASYNC) [*5];
  endsequence
  sequence ack_s;
    mode_select_pins == PMC_MODE_SYNC && rdy_busy_oe && $rose(rdy_busy_o);
  endsequence
  sequence busy_s;
    mode_select_pins == PMC_MODE_ASYNC && rdy_busy_oe && $fell(rdy_busy_o);
  endsequence
  ////////////////////////////////////////
  read_drive_a: assert property (@(posedge clk_sys) disable iff (reset)
    rd_hold_s |-> config_byte_bus_oe == {DATA_W{1'b1}}) else $error("bus not driven");
  bus_release_a: assert property (@(posedge clk_sys) disable iff (reset)
    (!rd_c) [*5] |-> config_byte_bus_oe == '0) else $error("bus not released");
  status_fill_a: assert property (@(posedge clk_sys) disable iff (reset)
    config_byte_bus_oe != '0 |-> config_byte_bus_o[6:0] == PMC_STATUS_FILL)
    else $error("status fill bits wrong");
  sync_decode_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_select_pins == PMC_MODE_SYNC) [*4] |-> sync_mode_active && !async_mode_active)
    else $error("sync mode not decoded");
  async_decode_a: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_select_pins == PMC_MODE_ASYNC) [*4] |-> async_mode_active && !sync_mode_active)
    else $error("async mode not decoded");
  ack_width_a: assert property (@(posedge config_clock) disable iff (reset)
    ack_s |=> !rdy_busy_o) else $error("ack longer than one period");
  ack_space_a: assert property (@(posedge config_clock) disable iff (reset)
    ack_s |=> (!rdy_busy_o) [*7] ##1 rdy_busy_o) else $error("capture spacing wrong");
  busy_len_a: assert property (@(posedge config_clock) disable iff (reset)
    busy_s |=> !rdy_busy_o ##[1:8] rdy_busy_o) else $error("busy length wrong");
  pull_only_a: assert property (@(posedge config_clock) disable iff (reset)
    (!init_pin) [*5] |-> !rdy_busy_oe) else $error("ready driven before init");
endmodule

bind pmc_config_loader pmc_config_monitor #(.DATA_W(DATA_W)) i_mon (
  .clk_sys(clk_sys), .reset(reset), .config_clock(config_clock),
  .mode_select_pins(mode_select_pins), .init_pin(init_pin),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
  .chip_select_lo_n(chip_select_lo_n), .chip_select_hi(chip_select_hi),
  .config_byte_bus_o(config_byte_bus_o), .config_byte_bus_oe(config_byte_bus_oe),
  .rdy_busy_o(rdy_busy_o), .rdy_busy_oe(rdy_busy_oe),
  .sync_mode_active(sync_mode_active), .async_mode_active(async_mode_active)
);

// [pmc_byte_source.sv]
// pmc_byte_source: external byte source for synchronous loading
// assumes: advances only on the device acknowledge
`timescale 1ns/1ps
module pmc_byte_source
  import pmc_pkg::*;
#(
  parameter logic [7:0] FIRST = 8'hA5,
  parameter logic [7:0] SECOND = 8'h3C
)
(
  // link clock and reset
  input wire logic config_clock,
  input wire logic reset,
  // device side
  input wire logic [2:0] mode_select_pins,
  input wire logic rdy_busy_o,
  input wire logic rdy_busy_oe,
  output logic [7:0] src_byte
);
  logic first_r;
  always_ff @(posedge config_clock) begin
    if (reset) begin
      first_r <= 1'b1;
      src_byte <= FIRST;
    end else if (mode_select_pins == PMC_MODE_SYNC && rdy_busy_oe && rdy_busy_o) begin
      // next byte held until the next capture
      first_r <= 1'b0;
      src_byte <= first_r ? SECOND : ~src_byte;
    end
  end
endmodule

// [tb_top.sv]
// tb_top: self-checking bench for the configuration loader
// assumes: monitor bound, byte source model compiled before
`timescale 1ns/1ps
module tb_top
  import pmc_pkg::*;
;
  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] pins;
    logic [7:0] oe;
    logic [7:0] dec;
  } pmc_row_s;
  logic clk_sys = 1'b0;
  logic config_clock = 1'b0;
  logic reset = 1'b1;
  logic init_pin = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [3:0] pins = 4'hF; // ws_n, rs_n, cs_lo_n, cs_hi
  logic [7:0] host_byte = 8'h00;
  logic [7:0] src_byte, bus_i, bus_o, bus_oe;
  logic rdy, rdy_oe, chain, cbit, cvalid, st_rdy, sync_on, async_on;
  logic bits_q[$];
  logic [7:0] wr [3] = '{8'h96, 8'h5A, 8'hC3};
  int num_errors = 0;
  int check_count = 0;
  int n;
  pmc_row_s rows [6] = '{'{3'h5, 4'h9, 8'hFF, 8'h1}, '{3'h5, 4'h8, 8'h00, 8'h1},
    '{3'h5, 4'hB, 8'h00, 8'h1}, '{3'h5, 4'h1, 8'h00, 8'h1},
    '{3'h3, 4'h9, 8'h00, 8'h2}, '{3'h0, 4'h9, 8'h00, 8'h0}};
  assign bus_i = (mode == PMC_MODE_SYNC) ? src_byte : host_byte;
  ////////////////////////////////////////
  pmc_config_loader i_pmc_config_loader (
    .clk_sys(clk_sys), .reset(reset), .config_clock(config_clock),
    .mode_select_pins(mode), .init_pin(init_pin), .write_strobe_n(pins[3]),
    .read_strobe_n(pins[2]), .chip_select_lo_n(pins[1]), .chip_select_hi(pins[0]),
    .config_byte_bus_i(bus_i), .config_byte_bus_o(bus_o), .config_byte_bus_oe(bus_oe),
    .rdy_busy_o(rdy), .rdy_busy_oe(rdy_oe), .serial_chain_out(chain), .cfg_bit(cbit),
    .cfg_bit_valid(cvalid), .status_ready(st_rdy), .sync_mode_active(sync_on),
    .async_mode_active(async_on));
  pmc_byte_source i_pmc_byte_source (
    .config_clock(config_clock), .reset(reset), .mode_select_pins(mode),
    .rdy_busy_o(rdy), .rdy_busy_oe(rdy_oe), .src_byte(src_byte));
  ////////////////////////////////////////
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #3.1;
    forever #7.5 config_clock = ~config_clock;
  end
  always @(posedge config_clock) begin
    if (cvalid === 1'b1) begin
      bits_q.push_back(cbit);
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic host_write(input logic [7:0] d);
    @(posedge clk_sys);
    host_byte <= d;
    pins <= 4'h5;
    for (n = 0; n < 60 && rdy !== 1'b1; n++) cyc(1);
    cyc(3); // end write only after ready stood a period
    @(posedge clk_sys);
    pins <= 4'hF;
    host_byte <= ~d;
    for (n = 0; n < 60 && rdy !== 1'b0; n++) cyc(1);
    chk("busy", 8'h0, {7'h0, rdy});
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    cyc(5);
    chk("oe in reset", 8'h0, bus_oe);
    chk("rdy oe in reset", 8'h0, {7'h0, rdy_oe});
    @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk_sys);
      mode <= rows[i].mode;
      pins <= rows[i].pins;
      cyc(6);
      chk("bus_oe", rows[i].oe, bus_oe);
      chk("bus_o", rows[i].oe, bus_o & rows[i].oe);
      chk("mode", rows[i].dec, {6'h0, sync_on, async_on});
    end
    @(posedge clk_sys);
    pins <= 4'hF;
    mode <= PMC_MODE_SYNC;
    init_pin <= 1'b1;
    for (n = 0; n < 40 && !(rdy_oe === 1'b1 && rdy === 1'b1); n++) @(posedge config_clock);
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 8; i++) begin
        @(posedge config_clock);
        chk("chain", {7'h0, b ? 1'(8'h3C >> i) : 1'(8'hA5 >> i)}, {7'h0, chain});
        if (i == 0) chk("ack end", 8'h0, {7'h0, rdy});
        if (i == 7) chk("ack next", 8'h1, {7'h0, rdy});
      end
    end
    repeat (12) @(posedge config_clock); // trailing link edges
    @(posedge clk_sys);
    reset <= 1'b1;
    init_pin <= 1'b0;
    mode <= PMC_MODE_ASYNC;
    cyc(6);
    @(posedge clk_sys);
    reset <= 1'b0;
    init_pin <= 1'b1;
    cyc(8);
    bits_q.delete();
    foreach (wr[i]) host_write(wr[i]);
    cyc(40);
    chk("bit count", 8'h17, 8'(bits_q.size()));
    for (int k = 0; k < 23; k++) chk("cfg_bit", {7'h0, wr[k / 8][k % 8]}, {7'h0, bits_q[k]});
    chk("parked", {7'h0, wr[2][6]}, {7'h0, chain});
    chk("status_ready", 8'h1, {7'h0, st_rdy});
    wrap_up();
  end
endmodule
